/* File: hw/mtp_timer_cfg.svh */
// offsets, field positions and reset values of the match timer
`ifndef MTP_TIMER_CFG_SVH
`define MTP_TIMER_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MTP_OFF_CTRL   8'h00
`define MTP_OFF_COUNT  8'h04
`define MTP_OFF_PRESC  8'h08
`define MTP_OFF_PCNT   8'h0c
`define MTP_OFF_MCTL   8'h10
`define MTP_OFF_MATCH0 8'h14
`define MTP_OFF_EXTOUT 8'h24
`define MTP_OFF_PWM    8'h28
`define MTP_OFF_CAPCTL 8'h2c
`define MTP_OFF_CAPVAL 8'h30
`define MTP_OFF_INTST  8'h34
`define MTP_OFF_INTMSK 8'h38

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MTP_CTRL_EN      0
`define MTP_CTRL_RST     1
`define MTP_MCTL_W       2
`define MTP_MCTL_RST     0
`define MTP_MCTL_STOP    1
`define MTP_EXT_ACT_LSB  4
`define MTP_CAP_RISE     0
`define MTP_CAP_FALL     1
`define MTP_INT_CAP      4
`define MTP_NUM_MATCH    4
`define MTP_NUM_OUT      2
`define MTP_INT_W        5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MTP_RST_CTRL   2'h0
`define MTP_RST_MCTL   8'h00
`define MTP_RST_EXTACT 4'h0
`define MTP_RST_PWM    2'h0
`define MTP_RST_CAPCTL 2'h0
`define MTP_RST_INT    5'h00

`endif

/* File: hw/mtp_pkg.sv */
// types shared by the match timer modules
package mtp_pkg;

  typedef enum logic [1:0] {
    MTP_ACT_NONE   = 2'h0,
    MTP_ACT_LOW    = 2'h1,
    MTP_ACT_HIGH   = 2'h2,
    MTP_ACT_TOGGLE = 2'h3
  } mtp_act_t;

endpackage : mtp_pkg

/* File: hw/mtp_edge_sync.sv */
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
`default_nettype none

module mtp_edge_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output var  logic rise_o,
  output var  logic fall_o
);

  logic s1;
  logic s2;
  logic s3;
  logic lvl;

  // ----------------------------------------------------------------
  // sync chain and filtered level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lvl    <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      if (s2 == s3) begin
        lvl <= s2;
      end
      rise_o <= (s2 == s3) & s2 & ~lvl;
      fall_o <= (s2 == s3) & ~s2 & lvl;
    end
  end

endmodule : mtp_edge_sync

`default_nettype wire

/* File: hw/mtp_match_out.sv */
// one external match output: action on match or single-edge pwm
`timescale 1ns/100ps
`default_nettype none

module mtp_match_out import mtp_pkg::*; (
  input  wire logic     sys_clk_i,
  input  wire logic     rst_i,
  input  wire logic     hit_i,
  input  wire logic     restart_i,
  input  wire logic     pwm_i,
  input  wire mtp_act_t act_i,
  output var  logic     out_o
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // output level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_o <= 1'b0;
    end else if (pwm_i) begin
      if (hit_i) begin
        out_o <= 1'b1;
      end else if (restart_i) begin
        out_o <= 1'b0;
      end
    end else if (hit_i) begin
      case (act_i)
        MTP_ACT_LOW:    out_o <= 1'b0;
        MTP_ACT_HIGH:   out_o <= 1'b1;
        MTP_ACT_TOGGLE: out_o <= ~out_o;
        default:        out_o <= out_o;
      endcase
    end
  end

  a_pwm_period_low: assert property (
    pwm_i && restart_i && !hit_i |=> !out_o)
    else $error("pwm output not low at period start");
  a_act_toggle: assert property (
    !pwm_i && hit_i && act_i == MTP_ACT_TOGGLE |=> out_o != $past(out_o))
    else $error("toggle action did not invert output");
  a_act_hold: assert property (
    !pwm_i && (!hit_i || act_i == MTP_ACT_NONE) |=> $stable(out_o))
    else $error("output changed without action");

endmodule : mtp_match_out

`default_nettype wire

/* File: hw/mtp_timer.sv */
// match timer with prescaler, four matches, pwm outputs and capture
`timescale 1ns/100ps
`default_nettype none
`include "mtp_timer_cfg.svh"

module mtp_timer import mtp_pkg::*; #(
  parameter int CNT_W = 32
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output var  logic        pready_o,
  output var  logic        pslverr_o,
  input  wire logic        cap_i,
  output var  logic [1:0]  mat_o,
  output var  logic        irq_o
);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  localparam int NM = `MTP_NUM_MATCH;
  localparam int NO = `MTP_NUM_OUT;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]        ctrl;
  logic [CNT_W-1:0]  tc;
  logic [CNT_W-1:0]  pr;
  logic [CNT_W-1:0]  pc;
  logic [7:0]        mctl;
  logic [CNT_W-1:0]  mr [NM];
  logic [3:0]        ext_act;
  logic [1:0]        pwm_en;
  logic [1:0]        capctl;
  logic [CNT_W-1:0]  cr;
  logic [4:0]        int_st;
  logic [4:0]        int_msk;

  logic              en;
  logic              crst;
  logic              acc;
  logic              wr;
  logic [7:0]        off;
  logic              tick;
  logic [NM-1:0]     hit;
  logic [NM-1:0]     rst_sel;
  logic [NM-1:0]     stop_sel;
  logic              any_rst;
  logic              any_stop;
  logic              restart;
  logic              cap_rise;
  logic              cap_fall;
  logic              cap_ev;
  logic [4:0]        ev;
  logic [1:0]        mat;
  logic [31:0]       next_rdata;
  logic              next_err;

  assign en   = ctrl[`MTP_CTRL_EN];
  assign crst = ctrl[`MTP_CTRL_RST];
  assign off  = paddr_i[7:0];
  assign acc  = psel_i & penable_i & pready_o;
  assign wr   = acc & pwrite_i;

  // ----------------------------------------------------------------
  // prescaler and match compare
  // ----------------------------------------------------------------
  assign tick = en & ~crst & (pc == pr);

  generate
    for (genvar i = 0; i < NM; i++) begin : g_match
      assign hit[i]      = tick & (tc == mr[i]);
      assign rst_sel[i]  = hit[i] & mctl[`MTP_MCTL_W*i + `MTP_MCTL_RST];
      assign stop_sel[i] = hit[i] & mctl[`MTP_MCTL_W*i + `MTP_MCTL_STOP];
    end
  endgenerate

  assign any_rst  = |rst_sel;
  assign any_stop = |stop_sel;
  assign restart  = any_rst;
  assign cap_ev   = (cap_rise & capctl[`MTP_CAP_RISE]) | (cap_fall & capctl[`MTP_CAP_FALL]);
  assign ev       = {cap_ev, hit};

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl <= `MTP_RST_CTRL;
    end else if (any_stop) begin
      ctrl[`MTP_CTRL_EN] <= 1'b0;
    end else if (wr && off == `MTP_OFF_CTRL) begin
      ctrl <= pwdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // prescale counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pc <= '0;
    end else if (wr && off == `MTP_OFF_PCNT) begin
      pc <= pwdata_i[CNT_W-1:0];
    end else if (crst || tick) begin
      pc <= '0;
    end else if (en) begin
      pc <= pc + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // main counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tc <= '0;
    end else if (wr && off == `MTP_OFF_COUNT) begin
      tc <= pwdata_i[CNT_W-1:0];
    end else if (crst) begin
      tc <= '0;
    end else if (tick) begin
      if (any_rst) begin
        tc <= '0;
      end else if (!any_stop) begin
        tc <= tc + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pr      <= '0;
      mctl    <= `MTP_RST_MCTL;
      ext_act <= `MTP_RST_EXTACT;
      pwm_en  <= `MTP_RST_PWM;
      capctl  <= `MTP_RST_CAPCTL;
      int_msk <= `MTP_RST_INT;
    end else if (wr) begin
      case (off)
        `MTP_OFF_PRESC:  pr      <= pwdata_i[CNT_W-1:0];
        `MTP_OFF_MCTL:   mctl    <= pwdata_i[7:0];
        `MTP_OFF_EXTOUT: ext_act <= pwdata_i[`MTP_EXT_ACT_LSB +: 4];
        `MTP_OFF_PWM:    pwm_en  <= pwdata_i[1:0];
        `MTP_OFF_CAPCTL: capctl  <= pwdata_i[1:0];
        `MTP_OFF_INTMSK: int_msk <= pwdata_i[4:0];
        default:         pr      <= pr;
      endcase
    end
  end

  generate
    for (genvar i = 0; i < NM; i++) begin : g_mreg
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          mr[i] <= '0;
        end else if (wr && off == 8'(`MTP_OFF_MATCH0 + 4*i)) begin
          mr[i] <= pwdata_i[CNT_W-1:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  mtp_edge_sync u_cap_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_i     (cap_i),
    .rise_o    (cap_rise),
    .fall_o    (cap_fall)
  );

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cr <= '0;
    end else if (cap_ev) begin
      cr <= tc;
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_st <= `MTP_RST_INT;
    end else if (wr && off == `MTP_OFF_INTST) begin
      int_st <= (int_st & ~pwdata_i[4:0]) | ev;
    end else begin
      int_st <= int_st | ev;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_st & int_msk);
    end
  end

  // ----------------------------------------------------------------
  // match outputs
  // ----------------------------------------------------------------
  generate
    for (genvar j = 0; j < NO; j++) begin : g_out
      mtp_match_out u_out (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .hit_i     (hit[j]),
        .restart_i (restart),
        .pwm_i     (pwm_en[j]),
        .act_i     (mtp_act_t'(ext_act[2*j +: 2])),
        .out_o     (mat[j])
      );
    end
  endgenerate

  assign mat_o = mat;

  // ----------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    case (off)
      `MTP_OFF_CTRL:   next_rdata = 32'(ctrl);
      `MTP_OFF_COUNT:  next_rdata = 32'(tc);
      `MTP_OFF_PRESC:  next_rdata = 32'(pr);
      `MTP_OFF_PCNT:   next_rdata = 32'(pc);
      `MTP_OFF_MCTL:   next_rdata = 32'(mctl);
      `MTP_OFF_MATCH0:         next_rdata = 32'(mr[0]);
      `MTP_OFF_MATCH0 + 8'h4:  next_rdata = 32'(mr[1]);
      `MTP_OFF_MATCH0 + 8'h8:  next_rdata = 32'(mr[2]);
      `MTP_OFF_MATCH0 + 8'hc:  next_rdata = 32'(mr[3]);
      `MTP_OFF_EXTOUT: next_rdata = {24'h0, ext_act, 2'h0, mat};
      `MTP_OFF_PWM:    next_rdata = 32'(pwm_en);
      `MTP_OFF_CAPCTL: next_rdata = 32'(capctl);
      `MTP_OFF_CAPVAL: next_rdata = 32'(cr);
      `MTP_OFF_INTST:  next_rdata = 32'(int_st);
      `MTP_OFF_INTMSK: next_rdata = 32'(int_msk);
      default:         next_err   = 1'b1;
    endcase
    if (paddr_i[31:8] != 24'h0 || paddr_i[1:0] != 2'h0) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & next_err;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        prdata_o <= next_err ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_presc_wrap: assert property (
    tick && !(wr && off == `MTP_OFF_PCNT) |=> pc == '0)
    else $error("prescaler did not wrap on tick");
  a_count_step: assert property (
    tick && !any_rst && !any_stop && !(wr && off == `MTP_OFF_COUNT)
    |=> tc == CNT_W'($past(tc) + 1'b1))
    else $error("counter did not advance on tick");
  a_idle_hold: assert property (
    !tick && !crst && !(wr && off == `MTP_OFF_COUNT) |=> $stable(tc))
    else $error("counter moved without a tick");
  a_match_reset: assert property (
    any_rst && !(wr && off == `MTP_OFF_COUNT) |=> tc == '0)
    else $error("reset on match failed");
  a_match_stop: assert property (
    any_stop |=> !en ##1 !tick)
    else $error("stop on match failed");
  a_cap_load: assert property (
    cap_ev |=> cr == $past(tc))
    else $error("capture did not load count");
  a_flag_sticky: assert property (
    ev[0] |=> int_st[0] ##1 (int_st[0] || $past(wr && off == `MTP_OFF_INTST)))
    else $error("match flag lost");
  a_irq_level: assert property (
    |(int_st & int_msk) |=> irq_o)
    else $error("interrupt not raised for enabled flag");
  a_apb_wait: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle");

endmodule : mtp_timer

`default_nettype wire

/* File: tb/mtp_pin_model.sv */
// pin partner: drives the capture pin and times the match output runs
`timescale 1ns/100ps
`default_nettype none

module mtp_pin_model (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        cap_req_i,
  input  wire logic [1:0]  mat_i,
  output var  logic        cap_o,
  output var  logic [15:0] hi0_o,
  output var  logic [15:0] hi1_o,
  output var  logic [15:0] lo1_o
);
  logic [15:0] run0;
  logic [15:0] run1;
  logic [1:0]  last;

  // ----------------------------------------------------------------
  // capture pin, changed just after a clock edge
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    cap_o <= cap_req_i;
  end

  // ----------------------------------------------------------------
  // length of the last high run of each output and the last low run of output 1
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    last <= mat_i;
    run0 <= (mat_i[0] != last[0]) ? 16'h1 : run0 + 16'h1;
    run1 <= (mat_i[1] != last[1]) ? 16'h1 : run1 + 16'h1;
    if (rst_i) begin
      hi0_o <= 16'h0;
      hi1_o <= 16'h0;
      lo1_o <= 16'h0;
    end else begin
      if (last[0] && !mat_i[0]) hi0_o <= run0;
      if (last[1] && !mat_i[1]) hi1_o <= run1;
      if (!last[1] && mat_i[1]) lo1_o <= run1;
    end
  end
endmodule : mtp_pin_model
`default_nettype wire

/* File: tb/mtp_timer_tb.sv */
// self-checking bench of the narrow match timer
`timescale 1ns/100ps
`default_nettype none
`include "mtp_timer_cfg.svh"

module mtp_timer_tb import mtp_pkg::*;;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        psel = 1'b0;
  logic        pen  = 1'b0;
  logic        pwr  = 1'b0;
  logic        creq = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        rdy;
  logic        err;
  logic        serr;
  logic        cap;
  logic        irq;
  logic [1:0]  mat;
  logic [15:0] hi0;
  logic [15:0] hi1;
  logic [15:0] lo1;
  int          fails = 0;
  int          checks = 0;
  int          cyc = 0;

  mtp_timer #(.CNT_W(16)) mtp_timer_i (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wdat), .prdata_o(rdat),
    .pready_o(rdy), .pslverr_o(err), .cap_i(cap), .mat_o(mat), .irq_o(irq));

  mtp_pin_model mtp_pin_model_i (.sys_clk_i(clk), .rst_i(rst), .cap_req_i(creq),
    .mat_i(mat), .cap_o(cap), .hi0_o(hi0), .hi1_o(hi1), .lo1_o(lo1));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    addr <= {24'h0, a};
    wdat <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd   = rdat;
    serr = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic out1_act(input mtp_act_t a);
    wr(`MTP_OFF_EXTOUT, {24'h0, a, 2'h3, 4'h0});
  endtask : out1_act

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc("ctrl", `MTP_OFF_CTRL, 32'h0);
    rdc("intst", `MTP_OFF_INTST, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", serr, 32'h1);
    wr(`MTP_OFF_PRESC, 32'hffffffff);
    rdc("presc", `MTP_OFF_PRESC, 32'h0000ffff);
    wr(`MTP_OFF_MATCH0 + 8'hc, 32'hffffffff);
    rdc("match3", `MTP_OFF_MATCH0 + 8'hc, 32'h0000ffff);
  endtask : t_reset

  task automatic t_pwm();
    wr(`MTP_OFF_PRESC, 32'h2);
    wr(`MTP_OFF_MATCH0, 32'h1);
    wr(`MTP_OFF_MATCH0 + 8'h4, 32'h2);
    wr(`MTP_OFF_MATCH0 + 8'h8, 32'h3);
    wr(`MTP_OFF_MCTL, 32'h10);
    wr(`MTP_OFF_EXTOUT, 32'h30);
    wr(`MTP_OFF_PWM, 32'h2);
    wr(`MTP_OFF_CTRL, 32'h1);
    idle(60);
    check("out0 high run", hi0, 32'd12);
    check("out1 high run", hi1, 32'd3);
    check("out1 low run", lo1, 32'd9);
  endtask : t_pwm

  task automatic t_actions();
    wr(`MTP_OFF_PWM, 32'h0);
    out1_act(MTP_ACT_HIGH);
    idle(30);
    check("out1 high", mat[1], 32'h1);
    out1_act(MTP_ACT_NONE);
    idle(36);
    check("out1 none", mat[1], 32'h1);
    out1_act(MTP_ACT_LOW);
    idle(30);
    check("out1 low", mat[1], 32'h0);
    out1_act(MTP_ACT_TOGGLE);
    idle(40);
    check("out1 toggle run", hi1, 32'd12);
  endtask : t_actions

  task automatic t_stop_irq();
    wr(`MTP_OFF_CTRL, 32'h0);
    wr(`MTP_OFF_COUNT, 32'h0);
    wr(`MTP_OFF_MCTL, 32'h80);
    wr(`MTP_OFF_MATCH0 + 8'hc, 32'h5);
    wr(`MTP_OFF_INTST, 32'h1f);
    wr(`MTP_OFF_INTMSK, 32'h08);
    wr(`MTP_OFF_CTRL, 32'h1);
    idle(40);
    rdc("count stop", `MTP_OFF_COUNT, 32'h5);
    rdc("ctrl stop", `MTP_OFF_CTRL, 32'h0);
    rdc("intst", `MTP_OFF_INTST, 32'h0f);
    check("irq set", irq, 32'h1);
    wr(`MTP_OFF_INTST, 32'h08);
    idle(2);
    check("irq masked", irq, 32'h0);
    rdc("intst clr", `MTP_OFF_INTST, 32'h07);
  endtask : t_stop_irq

  task automatic t_capture();
    wr(`MTP_OFF_INTST, 32'h1f);
    wr(`MTP_OFF_INTMSK, 32'h10);
    wr(`MTP_OFF_CAPCTL, 32'h2);
    @(posedge clk) creq <= 1'b1;
    idle(10);
    rdc("cap rise ignored", `MTP_OFF_INTST, 32'h0);
    @(posedge clk) creq <= 1'b0;
    idle(10);
    rdc("cap fall", `MTP_OFF_CAPVAL, 32'h5);
    rdc("cap flag", `MTP_OFF_INTST, 32'h10);
    check("cap irq", irq, 32'h1);
    wr(`MTP_OFF_INTST, 32'h1f);
    wr(`MTP_OFF_CAPCTL, 32'h1);
    wr(`MTP_OFF_COUNT, 32'h7);
    @(posedge clk) creq <= 1'b1;
    idle(10);
    rdc("cap rise", `MTP_OFF_CAPVAL, 32'h7);
  endtask : t_capture

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pwm();
    t_actions();
    t_stop_irq();
    t_capture();
    final_report();
  end
endmodule : mtp_timer_tb
`default_nettype wire
